// [rtl/pin_mux_defs.vh]
// constants for the port d / port e alternate function mux
`ifndef PIN_MUX_DEFS_VH
`define PIN_MUX_DEFS_VH

// byte offsets of the bus registers
`define REG_CTRL        8'h00
`define REG_PD_LATCH    8'h04
`define REG_PD_DIR      8'h08
`define REG_PE_LATCH    8'h0c
`define REG_PE_DIR      8'h10
`define REG_PD_PINS     8'h14
`define REG_PE_PINS     8'h18
`define REG_OUT_MODE    8'h1c

// register index codes returned by the decode function
`define IDX_CTRL        3'h0
`define IDX_PD_LATCH    3'h1
`define IDX_PD_DIR      3'h2
`define IDX_PE_LATCH    3'h3
`define IDX_PE_DIR      3'h4
`define IDX_PD_PINS     3'h5
`define IDX_PE_PINS     3'h6
`define IDX_OUT_MODE    3'h7

// control register field
`define CTRL_PULLUP_OFF 0

// widths and reset values
`define PD_WIDTH        8
`define PE_WIDTH        3
`define PIN_COUNT       11
`define PE_BASE         8
`define PD_RESET        8'h00
`define PE_RESET        3'h0

// ahb-lite codes
`define HTRANS_NONSEQ   2'h2
`define HTRANS_SEQ      2'h3
`define HRESP_OKAY      1'b0

`endif

// [rtl/pin_override_cell.v]
// one pad: synchroniser plus override selection of four pin attributes
`timescale 1ns/10ps
module pin_override_cell (
   // clock and reset
   input  wire core_clk,
   input  wire reset_n,
   // plain port control
   input  wire port_latch,
   input  wire port_dir,
   input  wire pullup_off,
   // overrides from peripherals
   input  wire pu_oe,
   input  wire pu_ov,
   input  wire dd_oe,
   input  wire dd_ov,
   input  wire pv_oe,
   input  wire pv_ov,
   input  wire ie_oe,
   input  wire ie_ov,
   // pad side
   input  wire pad_in,
   output wire pad_out,
   output wire pad_oe,
   output wire pad_pullup,
   // gated sample toward peripherals and pin register
   output wire pin_value
);

   reg  pad_meta_q;
   reg  pad_sync_q;
   wire base_pullup;
   wire input_en;

   // two flops: the pad is asynchronous to core_clk
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pad_meta_q <= 1'b0;
         pad_sync_q <= 1'b0;
      end else begin
         pad_meta_q <= pad_in;
         pad_sync_q <= pad_meta_q;
      end
   end

   // plain port pull-up: input mode, latch high, not globally off
   assign base_pullup = port_latch & ~port_dir & ~pullup_off;

   assign pad_pullup = pu_oe ? pu_ov : base_pullup;
   assign pad_oe     = dd_oe ? dd_ov : port_dir;
   assign pad_out    = pv_oe ? pv_ov : port_latch;
   assign input_en   = ie_oe ? ie_ov : 1'b1;

   // gated input reads low, so a floating oscillator pin reads quiet
   assign pin_value  = pad_sync_q & input_en;

endmodule

// [rtl/port_d_e_alt_function_mux.v]
// port d / port e alternate function mux with an ahb-lite register slave
//
// Behaviour
// - pd2 feeds irq0; gate forced on when enabled
// - pd2 serial1 clock direction from pd2 select
// - pd2 clock function only in synchronous mode
// - transmitter enable forces pd1 output, tx data
// - receiver enable forces pd0 input, feeds rx
// - pd0 pull-up follows latch and global off
// - memory enable overrides pd7/pd6 as strobes
// - timer2 async forces pd5/pd4 all off
// - pd5 compare a; pd4 clock else t3 compare
// - pe2 value from compare b when enabled
// - compare b needs pe2 direction bit set
// - pe2 also carries timer1 pwm waveform
// - memory enable overrides pe1 as address latch
// - pe0 feeds timer1 input capture
// - pe0 feeds irq2; gate forced on when enabled
// - only pe1 direction and pull-up overridden
//
// Decided for this implementation: the register offsets and register access over AHB-Lite.
`timescale 1ns/10ps
`include "pin_mux_defs.vh"
module port_d_e_alt_function_mux (
   // clock and reset
   input  wire                  core_clk,
   input  wire                  reset_n,
   // ahb-lite slave
   input  wire                  hsel,
   input  wire [31:0]           haddr,
   input  wire [1:0]            htrans,
   input  wire                  hwrite,
   input  wire [2:0]            hsize,
   input  wire [31:0]           hwdata,
   input  wire                  hready,
   output wire                  hreadyout,
   output wire                  hresp,
   output reg  [31:0]           hrdata,
   // first serial unit
   input  wire                  serial0_tx_enable,
   input  wire                  serial0_rx_enable,
   input  wire                  serial0_tx_pin,
   output wire                  serial0_rx_pin,
   input  wire                  serial0_clk_out_enable,
   input  wire                  serial0_ext_clock,
   output wire                  serial0_clk_in,
   // second serial unit
   input  wire                  serial1_sync_mode,
   input  wire                  serial1_ext_clock,
   output wire                  serial1_clk_in,
   // external memory strobes
   input  wire                  ext_mem_enable,
   input  wire                  mem_read_strobe,
   input  wire                  mem_write_strobe,
   input  wire                  mem_addr_latch,
   // timers
   input  wire                  timer2_async_select,
   input  wire                  t1_compare_a_enable,
   input  wire                  t1_compare_a_out,
   input  wire                  t3_compare_a_enable,
   input  wire                  t3_compare_a_out,
   input  wire                  t1_compare_b_enable,
   input  wire                  t1_compare_b_out,
   output wire                  t1_capture_input,
   // external interrupts
   input  wire                  ext_irq0_enable,
   input  wire                  ext_irq2_enable,
   output wire                  ext_irq0_input,
   output wire                  ext_irq2_input,
   // port d pads
   input  wire [`PD_WIDTH-1:0]  pd_pad_in,
   output wire [`PD_WIDTH-1:0]  pd_pad_out,
   output wire [`PD_WIDTH-1:0]  pd_pad_oe,
   output wire [`PD_WIDTH-1:0]  pd_pad_pullup,
   // port e pads
   input  wire [`PE_WIDTH-1:0]  pe_pad_in,
   output wire [`PE_WIDTH-1:0]  pe_pad_out,
   output wire [`PE_WIDTH-1:0]  pe_pad_oe,
   output wire [`PE_WIDTH-1:0]  pe_pad_pullup
);

   // register file
   reg                    global_pullup_off_q;
   reg  [`PD_WIDTH-1:0]   pd_latch_q;
   reg  [`PD_WIDTH-1:0]   pd_dir_q;
   reg  [`PE_WIDTH-1:0]   pe_latch_q;
   reg  [`PE_WIDTH-1:0]   pe_dir_q;

   // ahb data phase state
   reg                    wr_pend_q;
   reg                    rd_pend_q;
   reg                    hit_q;
   reg  [2:0]             idx_q;

   // per-pin override vectors
   reg  [`PIN_COUNT-1:0]  pu_oe;
   reg  [`PIN_COUNT-1:0]  pu_ov;
   reg  [`PIN_COUNT-1:0]  dd_oe;
   reg  [`PIN_COUNT-1:0]  dd_ov;
   reg  [`PIN_COUNT-1:0]  pv_oe;
   reg  [`PIN_COUNT-1:0]  pv_ov;
   reg  [`PIN_COUNT-1:0]  ie_oe;
   reg  [`PIN_COUNT-1:0]  ie_ov;

   wire [`PIN_COUNT-1:0]  all_latch;
   wire [`PIN_COUNT-1:0]  all_dir;
   wire [`PIN_COUNT-1:0]  all_pad_in;
   wire [`PIN_COUNT-1:0]  all_pad_out;
   wire [`PIN_COUNT-1:0]  all_pad_oe;
   wire [`PIN_COUNT-1:0]  all_pad_pullup;
   wire [`PIN_COUNT-1:0]  pin_value;

   wire                   addr_phase;
   wire [3:0]             addr_dec;
   wire                   addr_hit;
   wire [2:0]             addr_idx;
   wire                   serial1_clk_drive;

   // map a byte address onto a register index; bit 3 flags a hit
   function [3:0] reg_decode;
      input [31:0] addr;
      begin
         case (addr[31:0])
            {24'h000000, `REG_CTRL}:     reg_decode = {1'b1, `IDX_CTRL};
            {24'h000000, `REG_PD_LATCH}: reg_decode = {1'b1, `IDX_PD_LATCH};
            {24'h000000, `REG_PD_DIR}:   reg_decode = {1'b1, `IDX_PD_DIR};
            {24'h000000, `REG_PE_LATCH}: reg_decode = {1'b1, `IDX_PE_LATCH};
            {24'h000000, `REG_PE_DIR}:   reg_decode = {1'b1, `IDX_PE_DIR};
            {24'h000000, `REG_PD_PINS}:  reg_decode = {1'b1, `IDX_PD_PINS};
            {24'h000000, `REG_PE_PINS}:  reg_decode = {1'b1, `IDX_PE_PINS};
            {24'h000000, `REG_OUT_MODE}: reg_decode = {1'b1, `IDX_OUT_MODE};
            default:                     reg_decode = 4'h0;
         endcase
      end
   endfunction

   // zero wait state slave, never errors
   assign hreadyout  = 1'b1;
   assign hresp      = `HRESP_OKAY;
   assign addr_phase = hsel & hready &
                       ((htrans == `HTRANS_NONSEQ) | (htrans == `HTRANS_SEQ));
   assign addr_dec   = reg_decode(haddr);
   assign addr_hit   = addr_dec[3];
   assign addr_idx   = addr_dec[2:0];

   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         hit_q     <= 1'b0;
         idx_q     <= 3'h0;
      end else if (hready) begin
         wr_pend_q <= addr_phase & hwrite;
         rd_pend_q <= addr_phase & ~hwrite;
         hit_q     <= addr_phase & addr_hit;
         idx_q     <= addr_idx;
      end
   end

   // writes land at the end of the data phase; pin registers are read-only
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         global_pullup_off_q <= 1'b0;
         pd_latch_q          <= `PD_RESET;
         pd_dir_q            <= `PD_RESET;
         pe_latch_q          <= `PE_RESET;
         pe_dir_q            <= `PE_RESET;
      end else if (wr_pend_q & hit_q) begin
         case (idx_q)
            `IDX_CTRL:
               global_pullup_off_q <= hwdata[`CTRL_PULLUP_OFF];
            `IDX_PD_LATCH: pd_latch_q <= hwdata[`PD_WIDTH-1:0];
            `IDX_PD_DIR:   pd_dir_q   <= hwdata[`PD_WIDTH-1:0];
            `IDX_PE_LATCH: pe_latch_q <= hwdata[`PE_WIDTH-1:0];
            `IDX_PE_DIR:   pe_dir_q   <= hwdata[`PE_WIDTH-1:0];
            default: begin
               global_pullup_off_q <= global_pullup_off_q;
            end
         endcase
      end
   end

   // read mux of registers, pin samples and pad enables; unmapped addresses read zero
   always @* begin
      hrdata = 32'h00000000;
      if (rd_pend_q & hit_q) begin
         case (idx_q)
            `IDX_CTRL:     hrdata = {31'h00000000, global_pullup_off_q};
            `IDX_PD_LATCH: hrdata = {24'h000000, pd_latch_q};
            `IDX_PD_DIR:   hrdata = {24'h000000, pd_dir_q};
            `IDX_PE_LATCH: hrdata = {29'h00000000, pe_latch_q};
            `IDX_PE_DIR:   hrdata = {29'h00000000, pe_dir_q};
            `IDX_PD_PINS:  hrdata = {24'h000000, pin_value[7:0]};
            `IDX_PE_PINS:  hrdata = {29'h00000000, pin_value[10:8]};
            `IDX_OUT_MODE: hrdata = {21'h000000, all_pad_oe};
            default:       hrdata = 32'h00000000;
         endcase
      end
   end

   // clock drives out only when pd2 direction selects output
   assign serial1_clk_drive = serial1_sync_mode & pd_dir_q[2];

   // no flops between peripheral enables and pads
   always @* begin
      pu_oe = {`PIN_COUNT{1'b0}};
      pu_ov = {`PIN_COUNT{1'b0}};
      dd_oe = {`PIN_COUNT{1'b0}};
      dd_ov = {`PIN_COUNT{1'b0}};
      pv_oe = {`PIN_COUNT{1'b0}};
      pv_ov = {`PIN_COUNT{1'b0}};
      ie_oe = {`PIN_COUNT{1'b0}};
      ie_ov = {`PIN_COUNT{1'b0}};
      // memory strobes own pd7 and pd6
      pu_oe[7] = ext_mem_enable;
      dd_oe[7] = ext_mem_enable;
      dd_ov[7] = 1'b1;
      pv_oe[7] = ext_mem_enable;
      pv_ov[7] = mem_read_strobe;
      ie_oe[7] = ext_mem_enable;
      pu_oe[6] = ext_mem_enable;
      dd_oe[6] = ext_mem_enable;
      dd_ov[6] = 1'b1;
      pv_oe[6] = ext_mem_enable;
      pv_ov[6] = mem_write_strobe;
      ie_oe[6] = ext_mem_enable;
      // oscillator pins cut off from the port
      pu_oe[5] = timer2_async_select;
      dd_oe[5] = timer2_async_select;
      ie_oe[5] = timer2_async_select;
      pu_oe[4] = timer2_async_select;
      dd_oe[4] = timer2_async_select;
      ie_oe[4] = timer2_async_select;
      // compare a on pd5, clock before compare on pd4
      pv_oe[5] = t1_compare_a_enable;
      pv_ov[5] = t1_compare_a_out;
      pv_oe[4] = serial0_clk_out_enable | t3_compare_a_enable;
      pv_ov[4] = serial0_clk_out_enable ? serial0_ext_clock
                                        : t3_compare_a_out;
      pv_oe[2] = serial1_clk_drive;
      pv_ov[2] = serial1_ext_clock;
      // input kept alive while irq0 enabled
      ie_oe[2] = ext_irq0_enable;
      ie_ov[2] = 1'b1;
      pu_oe[1] = serial0_tx_enable;
      dd_oe[1] = serial0_tx_enable;
      dd_ov[1] = 1'b1;
      pv_oe[1] = serial0_tx_enable;
      pv_ov[1] = serial0_tx_pin;
      dd_oe[0] = serial0_rx_enable;
      pu_oe[0] = serial0_rx_enable;
      pu_ov[0] = pd_latch_q[0] & ~global_pullup_off_q;
      // pwm waveform arrives on the same compare line
      pv_oe[`PE_BASE+2] = t1_compare_b_enable;
      pv_ov[`PE_BASE+2] = t1_compare_b_out;
      // the only port e pin with pull-up and direction overrides
      pu_oe[`PE_BASE+1] = ext_mem_enable;
      dd_oe[`PE_BASE+1] = ext_mem_enable;
      dd_ov[`PE_BASE+1] = 1'b1;
      pv_oe[`PE_BASE+1] = ext_mem_enable;
      pv_ov[`PE_BASE+1] = mem_addr_latch;
      // input kept alive while irq2 enabled
      ie_oe[`PE_BASE] = ext_irq2_enable;
      ie_ov[`PE_BASE] = 1'b1;
   end

   assign all_latch  = {pe_latch_q, pd_latch_q};
   assign all_dir    = {pe_dir_q, pd_dir_q};
   assign all_pad_in = {pe_pad_in, pd_pad_in};

   genvar gi;
   generate
      for (gi = 0; gi < `PIN_COUNT; gi = gi + 1) begin : g_pin
         pin_override_cell u_cell (
            .core_clk   (core_clk),
            .reset_n    (reset_n),
            .port_latch (all_latch[gi]),
            .port_dir   (all_dir[gi]),
            .pullup_off (global_pullup_off_q),
            .pu_oe      (pu_oe[gi]),
            .pu_ov      (pu_ov[gi]),
            .dd_oe      (dd_oe[gi]),
            .dd_ov      (dd_ov[gi]),
            .pv_oe      (pv_oe[gi]),
            .pv_ov      (pv_ov[gi]),
            .ie_oe      (ie_oe[gi]),
            .ie_ov      (ie_ov[gi]),
            .pad_in     (all_pad_in[gi]),
            .pad_out    (all_pad_out[gi]),
            .pad_oe     (all_pad_oe[gi]),
            .pad_pullup (all_pad_pullup[gi]),
            .pin_value  (pin_value[gi])
         );
      end
   endgenerate

   // pe2 direction comes only from its own bit
   assign pe_pad_oe     = all_pad_oe[10:8];
   assign pe_pad_out    = all_pad_out[10:8];
   assign pe_pad_pullup = all_pad_pullup[10:8];
   assign pd_pad_oe     = all_pad_oe[7:0];
   assign pd_pad_out    = all_pad_out[7:0];
   assign pd_pad_pullup = all_pad_pullup[7:0];

   assign ext_irq0_input   = pin_value[2];
   // clock input idle outside synchronous mode
   assign serial1_clk_in   = pin_value[2] & serial1_sync_mode;
   assign serial0_rx_pin   = pin_value[0];
   assign serial0_clk_in   = pin_value[4];
   assign t1_capture_input = pin_value[`PE_BASE];
   assign ext_irq2_input   = pin_value[`PE_BASE];

endmodule

// [tb/port_mux_assertions.sv]
// checker for pad overrides and sample paths of the port d / e mux
`timescale 1ns/10ps
module port_mux_assertions (
   // clock and reset
   input wire       core_clk,
   input wire       reset_n,
   // first serial unit
   input wire       serial0_tx_enable,
   input wire       serial0_rx_enable,
   input wire       serial0_tx_pin,
   input wire       serial0_rx_pin,
   input wire       serial0_clk_out_enable,
   input wire       serial0_ext_clock,
   input wire       serial0_clk_in,
   // second serial unit
   input wire       serial1_sync_mode,
   input wire       serial1_clk_in,
   // external memory and oscillator
   input wire       ext_mem_enable,
   input wire       mem_read_strobe,
   input wire       mem_write_strobe,
   input wire       mem_addr_latch,
   input wire       timer2_async_select,
   // timers and interrupts
   input wire       t1_compare_a_enable,
   input wire       t1_compare_a_out,
   input wire       t3_compare_a_enable,
   input wire       t3_compare_a_out,
   input wire       t1_compare_b_enable,
   input wire       t1_compare_b_out,
   input wire       t1_capture_input,
   input wire       ext_irq0_input,
   input wire       ext_irq2_input,
   // pads
   input wire [7:0] pd_pad_in,
   input wire [7:0] pd_pad_out,
   input wire [7:0] pd_pad_oe,
   input wire [7:0] pd_pad_pullup,
   input wire [2:0] pe_pad_in,
   input wire [2:0] pe_pad_out,
   input wire [2:0] pe_pad_oe,
   input wire [2:0] pe_pad_pullup
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   // four steady samples cover the two-flop synchroniser
   sequence pd0_still; $stable(pd_pad_in[0]) [*4]; endsequence
   sequence pd2_still; $stable(pd_pad_in[2]) [*4]; endsequence
   sequence pe0_still; $stable(pe_pad_in[0]) [*4]; endsequence
   sequence osc_held; timer2_async_select [*4]; endsequence

   irq0_path_a: assert property (pd2_still |->
      ext_irq0_input == pd_pad_in[2] &&
      serial1_clk_in == (pd_pad_in[2] && serial1_sync_mode))
      else $error("pd2 sample path wrong");
   rx_path_a: assert property (pd0_still |->
      serial0_rx_pin == pd_pad_in[0]) else $error("pd0 sample wrong");
   capture_path_a: assert property (pe0_still |->
      t1_capture_input == pe_pad_in[0] && ext_irq2_input == pe_pad_in[0])
      else $error("pe0 sample path wrong");
   osc_gate_a: assert property (osc_held |-> !serial0_clk_in)
      else $error("pd4 input not gated off");
   rx_input_a: assert property (serial0_rx_enable |->
      !pd_pad_oe[0]) else $error("pd0 not forced input");
   tx_force_a: assert property (serial0_tx_enable |->
      pd_pad_oe[1] && !pd_pad_pullup[1] && pd_pad_out[1] == serial0_tx_pin)
      else $error("pd1 transmit override wrong");
   mem_strobe_a: assert property (ext_mem_enable |->
      pd_pad_oe[7:6] == 2'b11 && pd_pad_pullup[7:6] == 2'b00 &&
      pd_pad_out[7:6] == {mem_read_strobe, mem_write_strobe})
      else $error("pd7 pd6 strobe override wrong");
   ale_force_a: assert property (ext_mem_enable |->
      pe_pad_oe[1] && !pe_pad_pullup[1] && pe_pad_out[1] == mem_addr_latch)
      else $error("pe1 latch override wrong");
   osc_off_a: assert property (timer2_async_select |->
      pd_pad_oe[5:4] == 2'b00 && pd_pad_pullup[5:4] == 2'b00)
      else $error("pd5 pd4 not released");
   pd4_clock_a: assert property (serial0_clk_out_enable |->
      pd_pad_out[4] == serial0_ext_clock) else $error("pd4 clock wrong");
   pd4_cmp_a: assert property (t3_compare_a_enable &&
      !serial0_clk_out_enable |-> pd_pad_out[4] == t3_compare_a_out)
      else $error("pd4 compare wrong");
   pd5_cmp_a: assert property (t1_compare_a_enable |->
      pd_pad_out[5] == t1_compare_a_out) else $error("pd5 compare wrong");
   cmp_b_a: assert property (t1_compare_b_enable |->
      pe_pad_out[2] == t1_compare_b_out) else $error("pe2 compare wrong");
endmodule
bind port_d_e_alt_function_mux port_mux_assertions chk (.*);

// [tb/pad_partner.sv]
// pad partner: resolves each pad level from both drivers and pull-up
`timescale 1ns/10ps
module pad_partner #(parameter W = 8) (
   // clock for the floating pattern
   input  wire         core_clk,
   // device side of the pads
   input  wire [W-1:0] pad_out,
   input  wire [W-1:0] pad_oe,
   input  wire [W-1:0] pad_pullup,
   // far side drive
   input  wire [W-1:0] ext_en,
   input  wire [W-1:0] ext_val,
   output wire [W-1:0] level
);
   // undriven pad without pull-up keeps changing, never a stale level
   logic [W-1:0] float_q = '0;
   always @(posedge core_clk) begin
      float_q <= ~float_q;
   end
   // device drive wins; far side only drives released pads
   assign level = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
                | (~pad_oe & ~ext_en & (pad_pullup | float_q));
endmodule

// [tb/port_d_e_alt_function_mux_tb_top.sv]
// self-checking bench for the port d / port e alternate function mux
`timescale 1ns/10ps
`include "pin_mux_defs.vh"
module port_d_e_alt_function_mux_tb_top;
   logic        core_clk = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, w;
   wire         hreadyout, hresp;
   wire  [31:0] hrdata;
   logic [19:0] per = 20'h0;
   logic [10:0] ext_en = 11'h0, ext_val = 11'h0;
   wire  [7:0]  pd_in, pd_out, pd_oe, pd_pu;
   wire  [2:0]  pe_in, pe_out, pe_oe, pe_pu;
   wire  [5:0]  smp;
   logic [31:0] regs [5];
   logic [10:0] e_out, e_oe, e_pu, gate, lvl, known;
   logic [5:0]  e_smp, k_smp;
   int          errors = 0, cmp_count = 0;
   int          msk [5] = '{1, 255, 255, 7, 7};

   always #4 core_clk = ~core_clk;

   port_d_e_alt_function_mux uut (.core_clk(core_clk), .reset_n(reset_n),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .serial0_tx_enable(per[0]), .serial0_rx_enable(per[1]),
      .serial0_tx_pin(per[2]), .serial0_rx_pin(smp[5]),
      .serial0_clk_out_enable(per[3]), .serial0_ext_clock(per[4]),
      .serial0_clk_in(smp[4]), .serial1_sync_mode(per[5]),
      .serial1_ext_clock(per[6]), .serial1_clk_in(smp[3]),
      .ext_mem_enable(per[7]), .mem_read_strobe(per[8]),
      .mem_write_strobe(per[9]), .mem_addr_latch(per[10]),
      .timer2_async_select(per[11]), .t1_compare_a_enable(per[12]),
      .t1_compare_a_out(per[13]), .t3_compare_a_enable(per[14]),
      .t3_compare_a_out(per[15]), .t1_compare_b_enable(per[16]),
      .t1_compare_b_out(per[17]), .t1_capture_input(smp[0]),
      .ext_irq0_enable(per[18]), .ext_irq2_enable(per[19]),
      .ext_irq0_input(smp[2]), .ext_irq2_input(smp[1]),
      .pd_pad_in(pd_in), .pd_pad_out(pd_out), .pd_pad_oe(pd_oe),
      .pd_pad_pullup(pd_pu), .pe_pad_in(pe_in), .pe_pad_out(pe_out),
      .pe_pad_oe(pe_oe), .pe_pad_pullup(pe_pu));
   pad_partner pd_side (.core_clk(core_clk), .pad_out(pd_out),
      .pad_oe(pd_oe), .pad_pullup(pd_pu), .ext_en(ext_en[7:0]),
      .ext_val(ext_val[7:0]), .level(pd_in));
   pad_partner #(.W(3)) pe_side (.core_clk(core_clk), .pad_out(pe_out),
      .pad_oe(pe_oe), .pad_pullup(pe_pu), .ext_en(ext_en[10:8]),
      .ext_val(ext_val[10:8]), .level(pe_in));

   task complete_run;
      $display("errors=%0d compares=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // masked bits are pads whose level nobody defines
   task chk_pin(input logic [10:0] got, exp, mk);
      cmp_count++;
      if (((got ^ exp) & mk) !== 11'h0) begin
         errors++;
         $display("[FAIL] %0t pins got %h exp %h", $time, got, exp);
      end
   endtask

   task chk_word(input logic [31:0] got, exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t read got %h exp %h", $time, got, exp);
      end
   endtask

   // no cycle limit here: only the watchdog ends a hung wait
   task wait_rdy;
      do
         @(posedge core_clk);
      while (hreadyout !== 1'b1);
   endtask

   // one single word transfer; entered just after a rising edge
   task bus(input logic wr, input logic [31:0] a, wd,
            output logic [31:0] r);
      haddr <= a;
      hwrite <= wr;
      htrans <= `HTRANS_NONSEQ;
      hsel <= 1'b1;
      wait_rdy();
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      wait_rdy();
      r = hrdata;
      chk_word({31'h0, hresp}, {31'h0, `HRESP_OKAY});
   endtask

   task model;
      e_out = {regs[3][2:0], regs[1][7:0]};
      e_oe = {regs[4][2:0], regs[2][7:0]};
      e_pu = e_out & ~e_oe & {11{~regs[0][0]}};
      gate = 11'h7ff;
      if (per[5] && regs[2][2]) e_out[2] = per[6];
      if (per[0]) {e_out[1], e_oe[1], e_pu[1]} = {per[2], 2'b10};
      if (per[1]) {e_oe[0], e_pu[0]} = {1'b0, regs[1][0] & ~regs[0][0]};
      if (per[7]) begin
         {e_out[7:6], e_oe[7:6], e_pu[7:6], gate[7:6]} = {per[8], per[9], 6'h30};
         {e_out[9], e_oe[9], e_pu[9]} = {per[10], 2'b10};
      end
      if (per[12]) e_out[5] = per[13];
      if (per[3]) e_out[4] = per[4];
      else if (per[14]) e_out[4] = per[15];
      if (per[11]) {e_oe[5:4], e_pu[5:4], gate[5:4]} = 6'h00;
      if (per[16]) e_out[10] = per[17];
      lvl = (e_oe & e_out) | (~e_oe & ext_en & ext_val) | (~e_oe & ~ext_en & e_pu);
      known = e_oe | ext_en | e_pu;
      e_smp = {lvl[0], lvl[4] & gate[4], lvl[2] & per[5], lvl[2], lvl[8], lvl[8]};
      k_smp = {known[0], known[4] | ~gate[4], known[2] | ~per[5], known[2],
               known[8], known[8]};
   endtask

   initial begin
      #400000;
      errors++;
      $display("[FAIL] %0t watchdog expired", $time);
      complete_run();
   end

   initial begin
      void'($urandom(32'h98bfc46d));
      repeat (12) @(posedge core_clk);
      reset_n <= 1'b1;
      @(posedge core_clk);
      // reset values, unmapped place at 0x20, read-only 0x1c
      bus(1'b1, 32'h1c, 32'hffffffff, rd);
      bus(1'b1, 32'h20, 32'hffffffff, rd);
      for (int a = 0; a < 36; a += 4) begin
         bus(1'b0, a, 32'h0, rd);
         if (a != 20 && a != 24) chk_word(rd, 32'h0);
      end
      for (int it = 0; it < 150; it++) begin
         for (int r = 0; r < 5; r++) begin
            w = $urandom;
            regs[r] = w & msk[r];
            bus(1'b1, 4 * r, w, rd);
            bus(1'b0, 4 * r, 32'h0, rd);
            chk_word(rd, regs[r]);
         end
         per <= 20'($urandom);
         ext_en <= 11'($urandom);
         ext_val <= 11'($urandom);
         // pads follow in the very cycle the enables change
         @(negedge core_clk);
         model();
         chk_pin({pe_out, pd_out}, e_out, 11'h7ff);
         chk_pin({pe_oe, pd_oe}, e_oe, 11'h7ff);
         chk_pin({pe_pu, pd_pu}, e_pu, 11'h7ff);
         repeat (4) @(posedge core_clk);
         @(negedge core_clk);
         chk_pin({5'h0, smp}, {5'h0, e_smp}, {5'h0, k_smp});
         @(posedge core_clk);
         bus(1'b0, 32'h14, 32'h0, rd);
         chk_pin(rd[10:0], {3'h0, lvl[7:0] & gate[7:0]},
                 {3'h7, known[7:0] | ~gate[7:0]});
         bus(1'b0, 32'h18, 32'h0, rd);
         chk_pin(rd[10:0], {8'h0, lvl[10:8]}, {8'hff, known[10:8]});
         bus(1'b0, 32'h1c, 32'h0, rd);
         chk_word(rd, {21'h0, e_oe});
      end
      complete_run();
   end
endmodule
